// ===== verilog/cvc_defs.svh
// Verb codes, node addresses, field layouts and reset values.
// Assumes: included by bare name wherever verbs are decoded.
`ifndef CVC_DEFS_SVH
`define CVC_DEFS_SVH
// ****************************************
// Node addresses
// ****************************************
`define CVC_NODE_PA 7'h10
`define CVC_NODE_PB 7'h11
`define CVC_NODE_CA 7'h12
// ****************************************
// Twelve-bit verbs, eight-bit parameter IDs and short verbs
// ****************************************
`define CVC_V_GET_PARAM 12'hF00
`define CVC_P_NODE_CAPABILITIES 8'h09
`define CVC_P_CONN_LEN 8'h0E
`define CVC_V_GET_CONN 12'hF02
`define CVC_V_GET_PROC 12'hF03
`define CVC_V_SET_PROC 12'h703
`define CVC_V_GET_PWR 12'hF05
`define CVC_V_SET_PWR 12'h705
`define CVC_V_GET_SCB 12'hF06
`define CVC_V_SET_SCB 12'h706
`define CVC_V_GET_SWAP 12'hF0C
`define CVC_V_SET_SWAP 12'h70C
`define CVC_V_GET_AMP_R 12'hB80
`define CVC_V_GET_AMP_L 12'hBA0
`define CVC_V_SET_AMP_R 12'h390
`define CVC_V_SET_AMP_L 12'h3A0
`define CVC_S_GET_FMT 4'hA
`define CVC_S_SET_FMT 4'h2
// ****************************************
// Fields and reset values
// ****************************************
`define CVC_PWR_OFF 2'h3
`define CVC_ACT_OFF 4'h3
`define CVC_SCB_RST 8'h00
`define CVC_FMT_RST 16'h0031
`define CVC_FMT_WR_MASK 16'h7F7F
`define CVC_AMP_RST 8'hFF
`define CVC_PROC_RST 8'h01
`define CVC_PROC_WR_MASK 8'h83
`define CVC_SWAP_BIT 2
`define CVC_NODE_CAPABILITIES_PB 32'h000D0C05
`define CVC_NODE_CAPABILITIES_CA 32'h001D0541
`define CVC_TYPE_VENDOR 4'hF
`define CVC_TYPE_OUT 4'h0
`define CVC_CONN_LEN 32'h00000001
`define CVC_CONN_LIST 32'h0000001D
`define CVC_SETTLE_EDGES 3'h4
`endif

// ===== verilog/cvc_pkg.sv
// Types shared by the converter control modules.
// Assumes: compiled before every module that imports it.
package cvc_pkg;
   // Power sequencing states, Gray along off-wake-on-sleep
   typedef enum logic [1:0]
   {
      cvc_ps_off = 2'h0,
      cvc_ps_wake = 2'h1,
      cvc_ps_on = 2'h3,
      cvc_ps_sleep = 2'h2
   } cvc_pwr_t;
endpackage

// ===== verilog/cvc_node_if.sv
// Carrier between verb decoder and one converter node.
// Assumes: one instance per converter, same clock on both ends.
`timescale 1ns/1ps
`default_nettype none
interface cvc_node_if;
   logic wr_pwr;
   logic wr_scb;
   logic wr_fmt;
   logic [15:0] wdata;
   logic link_edge;
   logic [1:0] pwr_set;
   logic [3:0] pwr_act;
   logic [7:0] scb;
   logic [15:0] fmt;
   logic active;
   modport ctl
   (
      output wr_pwr, wr_scb, wr_fmt, wdata, link_edge,
      input pwr_set, pwr_act, scb, fmt, active
   );
   modport node
   (
      input wr_pwr, wr_scb, wr_fmt, wdata, link_edge,
      output pwr_set, pwr_act, scb, fmt, active
   );
endinterface
`default_nettype wire

// ===== verilog/cvc_node.sv
// One converter node: power sequencing, stream binding, format.
// Assumes: link_edge is a one-cycle pulse per link bit clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "cvc_defs.svh"
module cvc_node
   import cvc_pkg::*;
#(
   parameter bit HAS_FMT = 1'b1
)
(
   input wire logic clk,
   input wire logic sys_rst,
   cvc_node_if.node bus
);
   cvc_pwr_t state;
   cvc_pwr_t next_state;
   logic [2:0] edges;
   logic [1:0] set_q;
   logic [3:0] act_q;
   logic [7:0] scb_q;
   logic [15:0] fmt_q;
   logic active_q;
   logic [7:0] lag;
   wire want_off = (set_q == `CVC_PWR_OFF);
   wire settled = (edges == `CVC_SETTLE_EDGES);
   wire [3:0] set_word = {2'h0, set_q};

   // ****************************************
   // Power sequencing
   // ****************************************
   always_comb
   begin
      next_state = state;
      case (state)
         cvc_ps_off: if (!want_off) next_state = cvc_ps_wake;
         cvc_ps_wake:
            if (want_off) next_state = cvc_ps_sleep;
            else if (settled) next_state = cvc_ps_on;
         cvc_ps_on: if (want_off) next_state = cvc_ps_sleep;
         cvc_ps_sleep:
            if (!want_off) next_state = cvc_ps_wake;
            else if (settled) next_state = cvc_ps_off;
         default: next_state = cvc_ps_off;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         state <= cvc_ps_off;
         edges <= 3'h0;
      end else begin
         state <= next_state;
         if (next_state != state) edges <= 3'h0;
         else if (bus.link_edge && !settled) edges <= edges + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) act_q <= `CVC_ACT_OFF;
      else if (next_state == cvc_ps_on) act_q <= set_word;
      else if (next_state == cvc_ps_off) act_q <= `CVC_ACT_OFF;
   end

   // ****************************************
   // Writable fields
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         set_q <= `CVC_PWR_OFF;
         scb_q <= `CVC_SCB_RST;
         fmt_q <= HAS_FMT ? `CVC_FMT_RST : 16'h0;
         active_q <= 1'b0;
      end else begin
         if (bus.wr_pwr) set_q <= bus.wdata[1:0];
         if (bus.wr_scb) scb_q <= bus.wdata[7:0];
         if (bus.wr_fmt && HAS_FMT)
            fmt_q <= bus.wdata & `CVC_FMT_WR_MASK;
         active_q <= (state == cvc_ps_on) && (scb_q[7:4] != 4'h0);
      end
   end

   assign bus.pwr_set = set_q;
   assign bus.pwr_act = act_q;
   assign bus.scb = scb_q;
   assign bus.fmt = fmt_q;
   assign bus.active = active_q;

   // Cycles for which the reported state lags the setting
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) lag <= 8'h0;
      else if (act_q == set_word) lag <= 8'h0;
      else if (lag != 8'hFF) lag <= lag + 8'h1;
   end

   pwr_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      lag != 8'hFF) else $error("power actual never caught up");
   stream_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      (scb_q[7:4] == 4'h0) |=> !active_q)
      else $error("converter active on stream zero");
   fmt_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      (bus.wr_fmt && HAS_FMT)
      |=> fmt_q == ($past(bus.wdata) & `CVC_FMT_WR_MASK))
      else $error("format write not loaded");
endmodule
`default_nettype wire

// ===== verilog/cvc_verbs.sv
// Verb decoder and control set for three converter nodes.
// Assumes: verbs arrive already framed in the clk domain; the link
// bit clock and the converter-enable strap are raw pins.
`timescale 1ns/1ps
`default_nettype none
`include "cvc_defs.svh"
module cvc_verbs
   import cvc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic link_bit_clk,
   input wire logic playback_b_enable,
   input wire logic cmd_valid,
   input wire logic [6:0] cmd_node,
   input wire logic [19:0] cmd_verb,
   output logic resp_valid,
   output logic [31:0] resp_data,
   output logic [2:0] conv_active,
   output logic pa_swap,
   output logic [15:0] pb_format,
   output logic [15:0] ca_format,
   output logic [7:0] pb_left_out,
   output logic [7:0] pb_right_out,
   output logic ca_hpf_enable,
   output logic ca_offset_calc_disable
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic lk_s1;
   logic lk_s2;
   logic lk_s3;
   logic en_s1;
   logic en_s2;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         lk_s1 <= 1'b0;
         lk_s2 <= 1'b0;
         lk_s3 <= 1'b0;
         en_s1 <= 1'b0;
         en_s2 <= 1'b0;
      end else begin
         lk_s1 <= link_bit_clk;
         lk_s2 <= lk_s1;
         lk_s3 <= lk_s2;
         en_s1 <= playback_b_enable;
         en_s2 <= en_s1;
      end
   end

   wire link_rise = lk_s2 && !lk_s3;

   // ****************************************
   // Verb decode
   // ****************************************
   function automatic logic is_verb
   (
      input logic [19:0] v,
      input logic [11:0] code
   );
      return v[19:8] == code;
   endfunction

   function automatic logic is_short
   (
      input logic [19:0] v,
      input logic [3:0] code
   );
      return v[19:16] == code;
   endfunction

   wire [7:0] pl8 = cmd_verb[7:0];
   wire [15:0] pl16 = cmd_verb[15:0];
   wire hit_pa = (cmd_node == `CVC_NODE_PA);
   wire hit_pb = (cmd_node == `CVC_NODE_PB);
   wire hit_ca = (cmd_node == `CVC_NODE_CA);
   wire [2:0] sel = {hit_ca, hit_pb, hit_pa};
   wire hit_any = cmd_valid && (sel != 3'h0);
   wire [1:0] idx = hit_ca ? 2'h2 : (hit_pb ? 2'h1 : 2'h0);
   wire is_param = is_verb(cmd_verb, `CVC_V_GET_PARAM);
   wire set_pwr = is_verb(cmd_verb, `CVC_V_SET_PWR);
   wire set_scb = is_verb(cmd_verb, `CVC_V_SET_SCB);
   wire set_fmt = is_short(cmd_verb, `CVC_S_SET_FMT);
   wire set_swap = is_verb(cmd_verb, `CVC_V_SET_SWAP);
   wire set_amp_r = is_verb(cmd_verb, `CVC_V_SET_AMP_R);
   wire set_amp_l = is_verb(cmd_verb, `CVC_V_SET_AMP_L);
   wire set_proc = is_verb(cmd_verb, `CVC_V_SET_PROC);
   wire any_set = set_pwr || set_scb || set_fmt || set_swap
      || set_amp_r || set_amp_l || set_proc;

   // ****************************************
   // Converter nodes
   // ****************************************
   cvc_node_if nif[3] ();
   logic [31:0] pwr_word [3];
   logic [31:0] scb_word [3];
   logic [31:0] fmt_word [3];

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_node
         assign nif[g].wr_pwr = cmd_valid && sel[g] && set_pwr;
         assign nif[g].wr_scb = cmd_valid && sel[g] && set_scb;
         assign nif[g].wr_fmt = cmd_valid && sel[g] && set_fmt;
         assign nif[g].wdata = pl16;
         assign nif[g].link_edge = link_rise;
         assign pwr_word[g] = {24'h0, nif[g].pwr_act, 2'h0,
            nif[g].pwr_set};
         assign scb_word[g] = {24'h0, nif[g].scb};
         assign fmt_word[g] = {16'h0, nif[g].fmt};
         cvc_node #(.HAS_FMT(g != 0)) u_node
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(nif[g])
         );
      end
   endgenerate

   // ****************************************
   // Local control fields
   // ****************************************
   logic pb_swap;
   logic [7:0] pb_amp_r;
   logic [7:0] pb_amp_l;
   logic [7:0] ca_proc;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         pa_swap <= 1'b0;
         pb_swap <= 1'b0;
         pb_amp_r <= `CVC_AMP_RST;
         pb_amp_l <= `CVC_AMP_RST;
         ca_proc <= `CVC_PROC_RST;
      end else if (cmd_valid) begin
         if (hit_pa && set_swap) pa_swap <= pl8[`CVC_SWAP_BIT];
         if (hit_pb && set_swap) pb_swap <= pl8[`CVC_SWAP_BIT];
         if (hit_pb && set_amp_r) pb_amp_r <= pl8;
         if (hit_pb && set_amp_l) pb_amp_l <= pl8;
         if (hit_ca && set_proc)
            ca_proc <= pl8 & `CVC_PROC_WR_MASK;
      end
   end

   // ****************************************
   // Capability words
   // ****************************************
   wire [3:0] pb_type = en_s2 ? `CVC_TYPE_OUT : `CVC_TYPE_VENDOR;
   wire [31:0] node_capabilities_pa = `CVC_NODE_CAPABILITIES_PB;
   wire [31:0] node_capabilities_pb = `CVC_NODE_CAPABILITIES_PB | {8'h0, pb_type, 20'h0};
   wire [31:0] node_capabilities_ca = `CVC_NODE_CAPABILITIES_CA;
   wire [31:0] node_capabilities_word = hit_ca ? node_capabilities_ca : (hit_pb ? node_capabilities_pb : node_capabilities_pa);
   wire pl_swap = hit_pb ? pb_swap : pa_swap;

   // ****************************************
   // Response select
   // ****************************************
   logic [31:0] next_resp;

   always_comb
   begin
      next_resp = 32'h0;
      if (!any_set) begin
         if (is_short(cmd_verb, `CVC_S_GET_FMT))
            next_resp = fmt_word[idx];
         else if (is_verb(cmd_verb, `CVC_V_GET_PWR))
            next_resp = pwr_word[idx];
         else if (is_verb(cmd_verb, `CVC_V_GET_SCB))
            next_resp = scb_word[idx];
         else if (is_param && pl8 == `CVC_P_NODE_CAPABILITIES)
            next_resp = node_capabilities_word;
         else if (is_verb(cmd_verb, `CVC_V_GET_SWAP) && !hit_ca)
            next_resp = {29'h0, pl_swap, 2'h0};
         else if (hit_pb && is_verb(cmd_verb, `CVC_V_GET_AMP_R))
            next_resp = {24'h0, pb_amp_r};
         else if (hit_pb && is_verb(cmd_verb, `CVC_V_GET_AMP_L))
            next_resp = {24'h0, pb_amp_l};
         else if (hit_ca && is_param && pl8 == `CVC_P_CONN_LEN)
            next_resp = `CVC_CONN_LEN;
         else if (hit_ca && is_verb(cmd_verb, `CVC_V_GET_CONN))
            next_resp = `CVC_CONN_LIST;
         else if (hit_ca && is_verb(cmd_verb, `CVC_V_GET_PROC))
            next_resp = {24'h0, ca_proc};
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
         resp_data <= 32'h0;
      end else begin
         resp_valid <= hit_any;
         resp_data <= hit_any ? next_resp : 32'h0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst) begin
         pb_left_out <= `CVC_AMP_RST;
         pb_right_out <= `CVC_AMP_RST;
         ca_hpf_enable <= 1'b1;
         ca_offset_calc_disable <= 1'b0;
         conv_active <= 3'h0;
         pb_format <= `CVC_FMT_RST;
         ca_format <= `CVC_FMT_RST;
      end else begin
         pb_left_out <= pb_swap ? pb_amp_r : pb_amp_l;
         pb_right_out <= pb_swap ? pb_amp_l : pb_amp_r;
         ca_hpf_enable <= (ca_proc[1:0] != 2'h0);
         ca_offset_calc_disable <= ca_proc[7];
         conv_active <= {nif[2].active, nif[1].active, nif[0].active};
         pb_format <= nif[1].fmt;
         ca_format <= nif[2].fmt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   set_resp_zero_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && any_set) |=> resp_valid && (resp_data == 32'h0))
      else $error("set verb answered non-zero");

   fmt_pcm_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && is_short(cmd_verb, `CVC_S_GET_FMT))
      |=> !resp_data[15])
      else $error("format stream type not zero");

   amp_write_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (cmd_valid && hit_pb && set_amp_r) |=> (pb_amp_r == $past(pl8)))
      else $error("right amp write lost");

   swap_path_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      pb_swap |=> (pb_left_out == $past(pb_amp_r)))
      else $error("swap did not cross channels");

   cap_type_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && hit_pb && is_param && pl8 == `CVC_P_NODE_CAPABILITIES)
      |=> resp_data[23:20] == ($past(en_s2) ? 4'h0 : 4'hF))
      else $error("capability type wrong");

   conn_list_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && hit_ca && is_verb(cmd_verb, `CVC_V_GET_CONN))
      |=> resp_data == 32'h0000001D)
      else $error("source list wrong");

   hpf_state_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (ca_proc[1:0] == 2'h0) ##1 (ca_proc[1:0] == 2'h0)
      |-> !ca_hpf_enable)
      else $error("high-pass not bypassed");

   pwr_read_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && is_verb(cmd_verb, `CVC_V_GET_PWR))
      |=> (resp_data[31:8] == 24'h0) && (resp_data[3:2] == 2'h0))
      else $error("power reserved bits set");

   conn_len_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && hit_ca && is_param && pl8 == `CVC_P_CONN_LEN)
      |=> resp_data == 32'h00000001)
      else $error("source list length wrong");

   swap_right_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      pb_swap |=> (pb_right_out == $past(pb_amp_l)))
      else $error("swap did not cross right channel");

   amp_left_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (cmd_valid && hit_pb && set_amp_l) |=> (pb_amp_l == $past(pl8)))
      else $error("left amp write lost");

   proc_write_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (cmd_valid && hit_ca && set_proc)
      |=> (ca_proc == ($past(pl8) & 8'h83)))
      else $error("processing write not masked");

   no_answer_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      !hit_any |=> !resp_valid && (resp_data == 32'h0))
      else $error("answer without matching node");

   pb_cap_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && hit_pb && is_param && pl8 == `CVC_P_NODE_CAPABILITIES)
      |=> (resp_data[31:24] == 8'h0) && (resp_data[19:0] == 20'hD0C05))
      else $error("playback capabilities wrong");

   ca_noswap_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (hit_any && hit_ca && is_verb(cmd_verb, `CVC_V_GET_SWAP))
      |=> (resp_data == 32'h0))
      else $error("capture swap read not zero");

   hpf_on_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      (ca_proc[1:0] != 2'h0) |=> ca_hpf_enable)
      else $error("high-pass not enabled");
endmodule
`default_nettype wire

// ===== tb/cvc_host.sv
// Host controller model: issues one verb at a time on the verb port.
// Assumes: the device registers its answer on the same clk edge that takes the verb.
`timescale 1ns/1ps
`default_nettype none
module cvc_host
(
   input wire logic clk,
   output logic cmd_valid,
   output logic [6:0] cmd_node,
   output logic [19:0] cmd_verb,
   input wire logic resp_valid,
   input wire logic [31:0] resp_data
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_node = 7'h00;
      cmd_verb = 20'h00000;
   end
   // ****************************************
   // Verb transfer
   // ****************************************
   task automatic send(input logic [6:0] node, input logic [19:0] verb,
                       output logic [31:0] resp, output logic got);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_node = node;
      cmd_verb = verb;
      @(posedge clk);
      #1;
      got = resp_valid;
      resp = resp_data;
      cmd_valid = 1'b0;
      // Idle lines carry junk so a stale verb cannot pass for a new one
      cmd_node = ~node;
      cmd_verb = ~verb;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter control set.
// Assumes: cvc_verbs top and the host model from cvc_host.sv.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic link_bit_clk = 1'b0;
   logic playback_b_enable = 1'b1;
   logic cmd_valid;
   logic [6:0] cmd_node;
   logic [19:0] cmd_verb;
   logic resp_valid;
   logic [31:0] resp_data;
   logic [2:0] conv_active;
   logic pa_swap;
   logic [15:0] pb_format;
   logic [15:0] ca_format;
   logic [7:0] pb_left_out;
   logic [7:0] pb_right_out;
   logic ca_hpf_enable;
   logic ca_offset_calc_disable;
   int num_errors = 0;
   int comparisons = 0;
   always #2.5 clk = ~clk;
   always #62.5 link_bit_clk = ~link_bit_clk;
   cvc_verbs i_dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .link_bit_clk(link_bit_clk),
      .playback_b_enable(playback_b_enable),
      .cmd_valid(cmd_valid),
      .cmd_node(cmd_node),
      .cmd_verb(cmd_verb),
      .resp_valid(resp_valid),
      .resp_data(resp_data),
      .conv_active(conv_active),
      .pa_swap(pa_swap),
      .pb_format(pb_format),
      .ca_format(ca_format),
      .pb_left_out(pb_left_out),
      .pb_right_out(pb_right_out),
      .ca_hpf_enable(ca_hpf_enable),
      .ca_offset_calc_disable(ca_offset_calc_disable)
   );
   cvc_host i_host
   (
      .clk(clk),
      .cmd_valid(cmd_valid),
      .cmd_node(cmd_node),
      .cmd_verb(cmd_verb),
      .resp_valid(resp_valid),
      .resp_data(resp_data)
   );
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic rd(input logic [6:0] n, input logic [19:0] v,
                     input logic [31:0] exp);
      logic [31:0] r;
      logic g;
      i_host.send(n, v, r, g);
      check({31'h0, g}, 32'h1);
      check(r, exp);
   endtask
   task automatic wr(input logic [6:0] n, input logic [19:0] v);
      rd(n, v, 32'h0);
   endtask
   // Polls the power word until it matches, bounded
   task automatic poll(input logic [6:0] n, input logic [31:0] exp);
      logic [31:0] r;
      logic g;
      int k;
      k = 0;
      r = 32'hFFFFFFFF;
      while (r !== exp && k < 400)
      begin
         i_host.send(n, 20'hF0500, r, g);
         k++;
      end
      if (r !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: power never settled", $time);
         final_report;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      for (int i = 0; i < 3; i++)
      begin
         rd(7'h10 + 7'(i), 20'hF0500, 32'h33);
         rd(7'h10 + 7'(i), 20'hF0600, 32'h0);
      end
      rd(7'h11, 20'hA0000, 32'h31);
      rd(7'h12, 20'hA0000, 32'h31);
      rd(7'h11, 20'hB8000, 32'hFF);
      rd(7'h11, 20'hBA000, 32'hFF);
      rd(7'h11, 20'hF0C00, 32'h0);
      rd(7'h12, 20'hF0300, 32'h1);
      rd(7'h10, 20'hF0009, 32'h000D0C05);
      rd(7'h11, 20'hF0009, 32'h000D0C05);
      rd(7'h12, 20'hF0009, 32'h001D0541);
      rd(7'h12, 20'hF000E, 32'h1);
      rd(7'h12, 20'hF0200, 32'h1D);
      check({pb_left_out, pb_right_out, 15'h0, ca_hpf_enable}, 32'hFFFF0001);
      check({pb_format, ca_format}, 32'h00310031);
      check({27'h0, conv_active, pa_swap, ca_offset_calc_disable}, 32'h0);
   endtask
   task automatic t_format;
      wr(7'h11, 20'h2FFFF);
      rd(7'h11, 20'hA0000, 32'h7F7F);
      wr(7'h12, 20'h24B17);
      rd(7'h12, 20'hA0000, 32'h4B17);
      check({pb_format, ca_format}, 32'h7F7F4B17);
   endtask
   task automatic t_amp_swap;
      wr(7'h11, 20'h39005);
      wr(7'h11, 20'h3A08A);
      rd(7'h11, 20'hB8000, 32'h05);
      rd(7'h11, 20'hBA000, 32'h8A);
      check({16'h0, pb_left_out, pb_right_out}, 32'h8A05);
      wr(7'h11, 20'h70CFF);
      rd(7'h11, 20'hF0C00, 32'h4);
      check({16'h0, pb_left_out, pb_right_out}, 32'h058A);
      wr(7'h10, 20'h70C04);
      rd(7'h10, 20'hF0C00, 32'h4);
      check({31'h0, pa_swap}, 32'h1);
   endtask
   task automatic t_power;
      wr(7'h10, 20'h70615);
      wr(7'h10, 20'h70500);
      check({29'h0, conv_active}, 32'h0);
      poll(7'h10, 32'h0);
      repeat (2) @(posedge clk);
      #1;
      check({29'h0, conv_active}, 32'h1);
      rd(7'h10, 20'hF0600, 32'h15);
      wr(7'h10, 20'h70605);
      rd(7'h10, 20'hF0600, 32'h5);
      check({29'h0, conv_active}, 32'h0);
      wr(7'h10, 20'h705F2);
      rd(7'h10, 20'hF0500, 32'h22);
      wr(7'h10, 20'h70503);
      poll(7'h10, 32'h33);
   endtask
   task automatic t_proc;
      wr(7'h12, 20'h703FF);
      rd(7'h12, 20'hF0300, 32'h83);
      check({30'h0, ca_offset_calc_disable, ca_hpf_enable}, 32'h3);
      wr(7'h12, 20'h70300);
      rd(7'h12, 20'hF0300, 32'h0);
      check({30'h0, ca_offset_calc_disable, ca_hpf_enable}, 32'h0);
   endtask
   task automatic t_strap_nodes;
      logic [31:0] r;
      logic g;
      playback_b_enable = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rd(7'h11, 20'hF0009, 32'h00FD0C05);
      playback_b_enable = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rd(7'h11, 20'hF0009, 32'h000D0C05);
      rd(7'h12, 20'hF0C00, 32'h0);
      i_host.send(7'h13, 20'hF0500, r, g);
      check({31'h0, g}, 32'h0);
      check(r, 32'h0);
      i_host.send(7'h00, 20'hF0009, r, g);
      check({31'h0, g}, 32'h0);
   endtask
   // Reset in mid-run must restore the control fields
   task automatic t_rerun;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({26'h0, resp_valid, pa_swap, ca_hpf_enable,
         ca_offset_calc_disable, conv_active}, 32'h10);
      sys_rst = 1'b0;
      rd(7'h10, 20'hF0C00, 32'h0);
      rd(7'h12, 20'hF0300, 32'h1);
      rd(7'h10, 20'hF0500, 32'h33);
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_reset;
      t_format;
      t_amp_swap;
      t_power;
      t_proc;
      t_strap_nodes;
      t_rerun;
      final_report;
   end
endmodule
`default_nettype wire
